// >>> design/ckl_params.svh
// Constants for the key and lifecycle control block.
`ifndef CKL_PARAMS_SVH
`define CKL_PARAMS_SVH
`define CKL_LC_DEBUG     4'h0
`define CKL_LC_SECURE    4'h2
`define CKL_LC_RESET     `CKL_LC_SECURE
`define CKL_KEY_WORDS    4
`define CKL_WORD_W       32
`define CKL_DMA_MAX_LEN  32'h0000ffff
`define CKL_SRAM_BASE    32'h10000000
`define CKL_SRAM_SIZE    32'h00010000
`endif

// >>> design/ckl_pkg.sv
// Types shared by the key and lifecycle control block.
package ckl_pkg;
  typedef enum logic [1:0] {
    CKL_SEL_DESIGN,
    CKL_SEL_ROOT,
    CKL_SEL_SESSION
  } ckl_key_sel_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  idx;
    logic [31:0] data;
  } ckl_word_wr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [31:0] len;
  } ckl_dma_req_t;
endpackage : ckl_pkg

// >>> design/ckl_ctrl.sv
// Lifecycle, root key, design key lock and key routing control.
// What this block does
// - Retain lifecycle, design key lock and root key.
// - Any reset clears all retained contents.
// - Only debug and secure lifecycle values valid.
// - Validity flag sets once valid lifecycle written.
// - Reset reads secure lifecycle with flag invalid.
// - Secure lifecycle: each root word written once.
// - Debug lifecycle: root words rewritable freely.
// - Selector routes design, root or session key.
// - Hard-coded design key never readable by software.
// - Lock write disables design key until reset.
// - Locked design key selected gives zero key.
// - Word zero reads retention status, not key.
// - DMA reaches on-chip SRAM only.
// - DMA transfer at most 2^16-1 bytes.
// - Enabled subsystem blocks the all-idle state.
// - Lock is write-once and retained.
`timescale 1ns/1ps
`default_nettype none
`include "ckl_params.svh"

module ckl_ctrl #(
  parameter logic [127:0] FIXED_KEY = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210, // Arbitrary value.
  parameter logic [31:0]  SRAM_BASE = `CKL_SRAM_BASE,
  parameter logic [31:0]  SRAM_SIZE = `CKL_SRAM_SIZE
) (
  // Clock, reset and enable
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // Software controls
  input  wire logic                   lc_wr,
  input  wire logic [3:0]             lc_wdata,
  input  wire ckl_pkg::ckl_word_wr_t  root_key_words_wr,
  input  wire logic                   fixed_key_lock_wr,
  input  wire ckl_pkg::ckl_key_sel_t  key_source_select,
  input  wire logic [127:0]           session_key,
  input  wire logic                   subsys_enable,
  // DMA request check
  input  wire ckl_pkg::ckl_dma_req_t  dma_req,
  // Status and key outputs
  output logic [3:0]                  lifecycle_state_q,
  output logic                        lifecycle_valid_flag_q,
  output logic                        fixed_key_lock_q,
  output logic [31:0]                 root_key_word0_q,
  output logic [127:0]                aes_key_q,
  output logic                        dma_grant_q,
  output logic                        dma_reject_q,
  output logic                        lowpower_allow_q
);
  import ckl_pkg::*;

  // All assertions and covers below run on the one system clock and are off while reset is applied.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // The window check adds in 33 bits, so a window that wraps past the top of the
  // address space cannot be served and is refused when the design is built.
  if (SRAM_SIZE == 32'h0 || ({1'b0, SRAM_BASE} + {1'b0, SRAM_SIZE}) > 33'h1_0000_0000) begin : g_bad_window
    $error("SRAM window must be non-empty and fit in the address space.");
  end

  // Retention-domain state: cleared only by reset, frozen by ce.
  logic [`CKL_KEY_WORDS-1:0][`CKL_WORD_W-1:0] rk_q;
  logic [`CKL_KEY_WORDS-1:0][`CKL_WORD_W-1:0] rk_d;
  logic [`CKL_KEY_WORDS-1:0]                  written_q;
  logic [`CKL_KEY_WORDS-1:0]                  written_d;
  logic [3:0]                                 lc_d;
  logic                                       lcv_d;
  logic                                       lock_d;
  logic                                       grant_d;
  logic                                       reject_d;
  logic                                       lp_d;
  logic [31:0]                                word0_d;
  logic [127:0]                               key_d;
  logic [32:0]                                dma_end;
  logic [32:0]                                win_end;
  logic                                       lc_legal;
  logic                                       rk_wr_ok;
  logic                                       dma_ok;

  always_comb begin
    lc_d      = lifecycle_state_q;
    lcv_d     = lifecycle_valid_flag_q;
    lock_d    = fixed_key_lock_q;
    rk_d      = rk_q;
    written_d = written_q;
    // The lifecycle is taken once per reset so a secure part cannot be moved back to debug.
    lc_legal  = (lc_wdata == `CKL_LC_DEBUG) || (lc_wdata == `CKL_LC_SECURE);
    if (lc_wr && !lifecycle_valid_flag_q && lc_legal) begin
      lc_d  = lc_wdata;
      lcv_d = 1'b1;
    end
    // A secure part keeps the first value of each word, so a loaded key cannot be swapped.
    rk_wr_ok = root_key_words_wr.valid && lifecycle_valid_flag_q &&
               ((lifecycle_state_q == `CKL_LC_DEBUG) ||
                !written_q[root_key_words_wr.idx]);
    if (rk_wr_ok) begin
      rk_d[root_key_words_wr.idx]      = root_key_words_wr.data;
      written_d[root_key_words_wr.idx] = 1'b1;
    end
    // Any write sets the lock; only a reset makes the design key usable again.
    if (fixed_key_lock_wr) begin
      lock_d = 1'b1;
    end
    // Word zero shows only the retained status; key bits never reach software through it.
    word0_d = {31'h0, &written_q};
    case (key_source_select)
      CKL_SEL_DESIGN:  key_d = fixed_key_lock_q ? 128'h0 : FIXED_KEY;
      CKL_SEL_ROOT:    key_d = rk_q;
      CKL_SEL_SESSION: key_d = session_key;
      default:         key_d = 128'h0;
    endcase
    // Sums are one bit wider so a request near the top of memory cannot wrap into the window.
    dma_end  = {1'b0, dma_req.addr} + {1'b0, dma_req.len};
    win_end  = {1'b0, SRAM_BASE} + {1'b0, SRAM_SIZE};
    dma_ok   = (dma_req.len != 32'h0) && (dma_req.len <= `CKL_DMA_MAX_LEN) &&
               (dma_req.addr >= SRAM_BASE) && (dma_end <= win_end);
    grant_d  = dma_req.valid && dma_ok;
    reject_d = dma_req.valid && !dma_ok;
    lp_d     = !subsys_enable;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      lifecycle_state_q      <= `CKL_LC_RESET;
      lifecycle_valid_flag_q <= 1'b0;
      fixed_key_lock_q       <= 1'b0;
      rk_q                   <= '0;
      written_q              <= '0;
      root_key_word0_q       <= 32'h0;
      aes_key_q              <= 128'h0;
      dma_grant_q            <= 1'b0;
      dma_reject_q           <= 1'b0;
      lowpower_allow_q       <= 1'b1;
    end else if (ce) begin
      lifecycle_state_q      <= lc_d;
      lifecycle_valid_flag_q <= lcv_d;
      fixed_key_lock_q       <= lock_d;
      rk_q                   <= rk_d;
      written_q              <= written_d;
      root_key_word0_q       <= word0_d;
      aes_key_q              <= key_d;
      dma_grant_q            <= grant_d;
      dma_reject_q           <= reject_d;
      lowpower_allow_q       <= lp_d;
    end
  end

  // Checks of the reset values and of the lifecycle come first.

  a_lc_reset_value: assert property ($past(rst) |-> lifecycle_state_q == `CKL_LC_RESET &&
                                     !lifecycle_valid_flag_q && !fixed_key_lock_q && written_q == '0)
    else $error("Retained state not cleared by reset.");
  a_lc_debug_take: assert property (ce && lc_wr && !lifecycle_valid_flag_q && lc_wdata == `CKL_LC_DEBUG
                                    |=> lifecycle_valid_flag_q && lifecycle_state_q == `CKL_LC_DEBUG)
    else $error("Legal lifecycle write not taken.");
  a_lc_bad_value: assert property (ce && lc_wr && !lifecycle_valid_flag_q && !lc_legal
                                   |=> !lifecycle_valid_flag_q && $stable(lifecycle_state_q))
    else $error("Illegal lifecycle write changed state.");
  a_lc_secure_take: assert property (ce && lc_wr && !lifecycle_valid_flag_q && lc_wdata == `CKL_LC_SECURE
                                     |=> lifecycle_valid_flag_q && lifecycle_state_q == `CKL_LC_SECURE)
    else $error("Legal secure lifecycle write not taken.");
  a_lc_taken_once: assert property (lifecycle_valid_flag_q
                                    |=> lifecycle_valid_flag_q && $stable(lifecycle_state_q))
    else $error("Configured lifecycle changed without reset.");

  a_rk_secure_once: assert property (ce && root_key_words_wr.valid && lifecycle_valid_flag_q &&
                                     lifecycle_state_q == `CKL_LC_SECURE && written_q[root_key_words_wr.idx]
                                     |=> $stable(rk_q))
    else $error("Second root key write accepted in secure lifecycle.");
  a_rk_debug_multi: assert property (ce && root_key_words_wr.valid && lifecycle_valid_flag_q &&
                                     lifecycle_state_q == `CKL_LC_DEBUG
                                     |=> rk_q[$past(root_key_words_wr.idx)] == $past(root_key_words_wr.data))
    else $error("Debug root key write lost.");
  a_rk_unconfigured: assert property (ce && root_key_words_wr.valid && !lifecycle_valid_flag_q
                                      |=> $stable(rk_q))
    else $error("Root key written before the lifecycle was configured.");

  a_lock_sticky: assert property (fixed_key_lock_q |=> fixed_key_lock_q)
    else $error("Design key lock cleared without reset.");
  a_lock_take: assert property (ce && fixed_key_lock_wr |=> fixed_key_lock_q)
    else $error("Design key lock write not taken.");
  a_lock_zero_key: assert property (ce && key_source_select == CKL_SEL_DESIGN && fixed_key_lock_q
                                    |=> aes_key_q == 128'h0)
    else $error("Locked design key reached the engine.");
  a_key_design_route: assert property (ce && key_source_select == CKL_SEL_DESIGN && !fixed_key_lock_q
                                       |=> aes_key_q == FIXED_KEY)
    else $error("Unlocked design key not routed.");
  a_key_session_route: assert property (ce && key_source_select == CKL_SEL_SESSION
                                        |=> aes_key_q == $past(session_key))
    else $error("Session key not routed.");
  a_key_root_route: assert property (ce && key_source_select == CKL_SEL_ROOT |=> aes_key_q == $past(rk_q))
    else $error("Root key not routed.");

  a_dma_len_limit: assert property (ce && dma_req.valid && dma_req.len > `CKL_DMA_MAX_LEN
                                    |=> !dma_grant_q && dma_reject_q)
    else $error("Oversized DMA request granted.");
  a_dma_sram_only: assert property (ce && dma_req.valid && dma_req.addr < SRAM_BASE |=> !dma_grant_q)
    else $error("DMA outside SRAM granted.");
  a_dma_one_answer: assert property (ce && dma_req.valid |=> dma_grant_q != dma_reject_q)
    else $error("DMA request not answered by exactly one of grant and reject.");
  a_lowpower_block: assert property (ce && subsys_enable |=> !lowpower_allow_q)
    else $error("Idle allowed while enabled.");
  a_lowpower_allow: assert property (ce && !subsys_enable |=> lowpower_allow_q)
    else $error("Idle refused while disabled.");

  a_status_word0: assert property (root_key_word0_q[0] |-> &written_q)
    else $error("Retention status set before key complete.");
  a_status_word0_set: assert property (ce && (&written_q) |=> root_key_word0_q == 32'h1)
    else $error("Retention status not shown after all four words.");
  a_ce_freeze: assert property (!ce |=> $stable(lifecycle_state_q) && $stable(lifecycle_valid_flag_q) &&
                                $stable(fixed_key_lock_q) && $stable(rk_q) && $stable(aes_key_q))
    else $error("State moved while the clock enable was low.");

  c_secure_locked: cover property (lifecycle_state_q == `CKL_LC_SECURE && lifecycle_valid_flag_q && fixed_key_lock_q);
  c_key_retained:  cover property (root_key_word0_q[0]);
  c_dma_grant:     cover property (dma_grant_q);
  c_dma_reject:    cover property (dma_reject_q);
  c_debug_rewrite: cover property (ce && rk_wr_ok && written_q[root_key_words_wr.idx]);
endmodule : ckl_ctrl
`default_nettype wire

// >>> testbench/ckl_ctrl_tb.sv
// Self-checking bench for the key and lifecycle control block.
`timescale 1ns/1ps
`default_nettype none
`include "ckl_params.svh"
module ckl_ctrl_tb;
  import ckl_pkg::*;
  localparam logic [127:0] FKEY = 128'h5a5a_0f0f_3c3c_9696_a5a5_f0f0_c3c3_6969; // Arbitrary value.
  localparam logic [31:0]  BASE = 32'h1000_0000;
  logic         mclk, rst, ce, lc_wr, lock_wr, sub_en, lcv, lockq, grant, rej, lp;
  logic [3:0]   lc_wdata, lc_state;
  logic [31:0]  w0;
  logic [127:0] sess, aes;
  ckl_word_wr_t kw;
  ckl_key_sel_t sel;
  ckl_dma_req_t dma;
  int           mismatches, samples_checked;

  ckl_ctrl #(.FIXED_KEY(FKEY), .SRAM_BASE(BASE), .SRAM_SIZE(32'h0001_0000)) DUT (
    .mclk(mclk), .rst(rst), .ce(ce), .lc_wr(lc_wr), .lc_wdata(lc_wdata), .root_key_words_wr(kw),
    .fixed_key_lock_wr(lock_wr), .key_source_select(sel), .session_key(sess), .subsys_enable(sub_en),
    .dma_req(dma), .lifecycle_state_q(lc_state), .lifecycle_valid_flag_q(lcv), .fixed_key_lock_q(lockq),
    .root_key_word0_q(w0), .aes_key_q(aes), .dma_grant_q(grant), .dma_reject_q(rej), .lowpower_allow_q(lp));

  task automatic chk(input string nm, input logic [127:0] exp, input logic [127:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // Strobes are left up so back-to-back requests never assign twice in one step.
  task automatic lc(input logic [3:0] v);
    lc_wr = 1'b1; lc_wdata = v; cyc(1);
  endtask : lc
  task automatic wk(input logic [1:0] i, input logic [31:0] d);
    kw = '{1'b1, i, d}; cyc(1);
  endtask : wk
  task automatic dm(input logic [31:0] a, input logic [31:0] l, input logic g);
    dma = '{1'b1, a, l}; cyc(1);
    chk("dma_grant", g, grant);
    chk("dma_reject", !g, rej);
  endtask : dm
  task automatic stop_test();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // The sequence needs about forty cycles; seventy-five times that means a hang.
  initial begin
    #300000;
    mismatches++;
    stop_test();
  end
  initial begin
    rst = 1'b1; ce = 1'b1; lc_wr = 1'b0; lc_wdata = 4'h0; kw = '0; lock_wr = 1'b0; sub_en = 1'b0; dma = '0;
    sel = CKL_SEL_ROOT; sess = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
    cyc(5); rst = 1'b0;
    chk("lc_state", `CKL_LC_SECURE, lc_state);
    chk("lc_valid", 1'b0, lcv);
    chk("word0", 32'h0, w0);
    chk("lowpower", 1'b1, lp);
    wk(2'h0, 32'hdead_beef); kw.valid = 1'b0; cyc(1);
    chk("early_key", 128'h0, aes);
    lc(4'h5);
    chk("bad_lc_valid", 1'b0, lcv);
    chk("bad_lc_state", `CKL_LC_SECURE, lc_state);
    lc(`CKL_LC_SECURE);
    chk("lc_valid", 1'b1, lcv);
    lc(`CKL_LC_DEBUG); lc_wr = 1'b0;
    chk("lc_state", `CKL_LC_SECURE, lc_state);
    for (int i = 0; i < 4; i++) wk(2'(i), 32'ha000_0000 + 32'(i));
    wk(2'h1, 32'h0); kw.valid = 1'b0; cyc(1);
    chk("root_key", {32'ha000_0003, 32'ha000_0002, 32'ha000_0001, 32'ha000_0000}, aes);
    chk("word0", 32'h1, w0);
    sel = CKL_SEL_SESSION; cyc(1);
    chk("session_key", sess, aes);
    sel = CKL_SEL_DESIGN; cyc(1);
    chk("design_key", FKEY, aes);
    sel = ckl_key_sel_t'(2'h3); cyc(1);
    chk("zero_key", 128'h0, aes);
    sel = CKL_SEL_DESIGN; lock_wr = 1'b1; cyc(1); lock_wr = 1'b0;
    chk("lock", 1'b1, lockq);
    cyc(3);
    chk("locked_key", 128'h0, aes);
    chk("lock_held", 1'b1, lockq);
    dm(BASE, 32'h10, 1'b1);
    dm(BASE, 32'hffff, 1'b1);
    dm(BASE, 32'h1_0000, 1'b0);
    dm(BASE, 32'h0, 1'b0);
    dm(32'h0, 32'h10, 1'b0);
    dm(BASE + 32'hfff0, 32'h10, 1'b1);
    dm(BASE + 32'hfff0, 32'h11, 1'b0);
    dma.valid = 1'b0; sub_en = 1'b1; cyc(1);
    chk("lowpower", 1'b0, lp);
    rst = 1'b1; cyc(1); rst = 1'b0;
    chk("lock_reset", 1'b0, lockq);
    chk("valid_reset", 1'b0, lcv);
    chk("state_reset", `CKL_LC_SECURE, lc_state);
    chk("word0_reset", 32'h0, w0);
    chk("key_reset", 128'h0, aes);
    cyc(1);
    chk("design_unlocked", FKEY, aes);
    lc(`CKL_LC_DEBUG); lc_wr = 1'b0; sel = CKL_SEL_ROOT;
    wk(2'h2, 32'h1); wk(2'h2, 32'h2); kw.valid = 1'b0; cyc(1);
    chk("debug_rewrite", {32'h0, 32'h2, 64'h0}, aes);
    // With the enable low neither a key word nor a lock write may land.
    ce = 1'b0; kw = '{1'b1, 2'h2, 32'h3}; lock_wr = 1'b1; cyc(1);
    chk("frozen_key", {32'h0, 32'h2, 64'h0}, aes);
    kw.valid = 1'b0; lock_wr = 1'b0; ce = 1'b1; cyc(1);
    chk("frozen_write_dropped", {32'h0, 32'h2, 64'h0}, aes);
    chk("frozen_lock", 1'b0, lockq);
    stop_test();
  end
endmodule : ckl_ctrl_tb
`default_nettype wire
